// ### gsm_mode_timing.sv
// Purpose: mode word of the graphics memory interface and command spacing guard
// Assumes: host strobes are synchronous to ref_clk; the sequencer issues one command a cycle
// Notes: the mode word survives soft_rst; traffic waits for a write after any reset
//
// Summary of operation
// RQ1: software writes mode word once after reset
// RQ2: soft reset keeps the mode word contents
// RQ3: cas latency code 011 or 010 only
// RQ4: bus width bit picks 64 or 32
// RQ5: geometry code sets address, bank, row, column bits
// RQ6: geometry 100 selects fast-cycle 12-bit addressing
// RQ7: refresh code 000 is 384, 111 1552
// RQ8: refresh codes 1..6 give 64 times n
// RQ9: read data to write gap two clocks
// RQ10: activate to column command zero..three clocks
// RQ11: bank active minimum two..seven clocks
// RQ12: precharge to activate one..three clocks
// RQ13: refresh to activate three..ten clocks
// RQ14: activate to activate two or three clocks
// RQ15: reserved bit 26 reads one, written zero
// RQ16: write recovery one or two clocks
// RQ17: timings are minimum spacings, never violated
// RQ18: no traffic before first mode write
`timescale 1ns/100ps
module gsm_mode_timing (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic soft_rst,
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [11:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    input wire logic cmd_valid,
    input wire gsm_pkg::gsm_cmd_t cmd_code,
    output logic cmd_ready,
    output logic refresh_req,
    output gsm_pkg::gsm_cfg_t cfg,
    output logic cfg_valid,
    output logic cfg_illegal
);
    import gsm_pkg::*;

    typedef struct packed {
        gsm_phase_t phase;
        logic [31:0] mode;
        logic ref_pending;
        logic [31:0] rdata;
        logic rvalid;
    } gsm_main_state_t;

    gsm_main_state_t st_r;
    gsm_main_state_t st_nxt;

    logic mode_hit;
    logic host_write;
    logic host_read;
    logic issue;
    logic ref_tick;
    logic [T_NUM-1:0] gap_start;
    logic [T_NUM-1:0][3:0] gap_span;
    logic [T_NUM-1:0] gap_done;

    // geometry table; unlisted codes decode to zero widths
    function automatic gsm_geom_t geom_decode(input logic [2:0] code);
        gsm_geom_t g;
        g = '0;
        unique case (code)
            GEO_15_9: g = '{1'b0, 4'hf, 2'h2, 4'hd, 4'h9}; // RQ5
            GEO_14_9: g = '{1'b0, 4'he, 2'h2, 4'hc, 4'h9}; // RQ5
            GEO_14_8A, GEO_14_8B: g = '{1'b0, 4'he, 2'h2, 4'hc, 4'h8}; // RQ5
            GEO_13_8: g = '{1'b0, 4'hd, 2'h2, 4'hb, 4'h8}; // RQ5
            GEO_FAST: g = '{1'b1, 4'hc, 2'h1, 4'hb, 4'h8}; // RQ6
            default: g = '0;
        endcase
        return g;
    endfunction : geom_decode

    // refresh interval in internal clocks
    function automatic logic [10:0] ref_decode(input logic [2:0] code);
        logic [10:0] n;
        n = {2'h0, code, 6'h00}; // RQ8
        if (code == 3'h0) begin
            n = REF_CODE0_CLK; // RQ7
        end else if (code == REF_CODE_MAX) begin
            n = REF_CODE7_CLK; // RQ7
        end
        return n;
    endfunction : ref_decode

    // forbidden code detection over all fields
    function automatic logic mode_bad(input logic [31:0] m);
        logic bad;
        bad = 1'b0;
        if (m[CL_LSB+:3] != CL_CODE_3 && m[CL_LSB+:3] != CL_CODE_2) begin
            bad = 1'b1; // RQ3
        end
        if (geom_decode(m[GEO_LSB+:3]).addr_bits == 4'h0) begin
            bad = 1'b1; // RQ5
        end
        if (m[GAP_LSB+:2] != GAP_CODE_A && m[GAP_LSB+:2] != GAP_CODE_B) begin
            bad = 1'b1; // RQ9
        end
        if (m[RAS_LSB+:3] < RAS_MIN_CODE) begin
            bad = 1'b1; // RQ11
        end
        if (m[RP_LSB+:2] < RP_MIN_CODE) begin
            bad = 1'b1; // RQ12
        end
        if (m[RC_LSB+:4] < RC_MIN_CODE || m[RC_LSB+:4] > RC_MAX_CODE) begin
            bad = 1'b1; // RQ13
        end
        if (m[RRD_LSB+:2] < RRD_MIN_CODE) begin
            bad = 1'b1; // RQ14
        end
        return bad;
    endfunction : mode_bad

    // decoded view of the stored mode word
    always_comb begin
        cfg.cas = {1'b0, st_r.mode[CL_LSB+:3]}; // RQ3
        cfg.wide_bus = st_r.mode[BW_BIT]; // RQ4
        cfg.geom = geom_decode(st_r.mode[GEO_LSB+:3]);
        cfg.ref_interval = ref_decode(st_r.mode[RTS_LSB+:3]);
        cfg.rcd = {2'h0, st_r.mode[RCD_LSB+:2]}; // RQ10
        cfg.ras = {1'b0, st_r.mode[RAS_LSB+:3]}; // RQ11
        cfg.rp = {2'h0, st_r.mode[RP_LSB+:2]}; // RQ12
        cfg.rc = st_r.mode[RC_LSB+:4]; // RQ13
        cfg.rrd = {2'h0, st_r.mode[RRD_LSB+:2]}; // RQ14
        cfg.wr = st_r.mode[WR_BIT] ? WR_SPAN_SET : WR_SPAN_CLR; // RQ16
        cfg.rd_wr = 4'(cfg.cas + RD_WR_GAP); // RQ9
    end

    assign cfg_valid = (st_r.phase == PH_RUN);
    assign cfg_illegal = mode_bad(st_r.mode);

    // host strobes
    assign mode_hit = host_sel && (host_addr == MODE_OFFSET);
    assign host_write = mode_hit && host_wr;
    assign host_read = host_sel && !host_wr;

    // command readiness: every spacing is a floor, the sequencer may only be later
    always_comb begin
        cmd_ready = 1'b0;
        if (cfg_valid) begin // RQ18
            unique case (cmd_code)
                CMD_NOP: cmd_ready = 1'b1;
                CMD_ACT: cmd_ready = gap_done[T_RP] && gap_done[T_RC] && gap_done[T_RRD]
                    && !st_r.ref_pending; // RQ17
                CMD_RD: cmd_ready = gap_done[T_RCD] && gap_done[T_WR]; // RQ17
                CMD_WR: cmd_ready = gap_done[T_RCD] && gap_done[T_RW]; // RQ17
                CMD_PRE: cmd_ready = gap_done[T_RAS] && gap_done[T_WR]; // RQ17
                CMD_REF: cmd_ready = gap_done[T_RP] && gap_done[T_RC]; // RQ17
                default: cmd_ready = 1'b0;
            endcase
        end
    end

    assign issue = cmd_valid && cmd_ready && (cmd_code != CMD_NOP);

    // which spacing each issued command starts
    always_comb begin
        gap_start = '0;
        gap_start[T_RCD] = issue && (cmd_code == CMD_ACT); // RQ10
        gap_start[T_RAS] = issue && (cmd_code == CMD_ACT); // RQ11
        gap_start[T_RRD] = issue && (cmd_code == CMD_ACT); // RQ14
        gap_start[T_RP] = issue && (cmd_code == CMD_PRE); // RQ12
        gap_start[T_RC] = issue && (cmd_code == CMD_REF); // RQ13
        gap_start[T_WR] = issue && (cmd_code == CMD_WR); // RQ16
        gap_start[T_RW] = issue && (cmd_code == CMD_RD); // RQ9
        gap_span[T_RCD] = cfg.rcd;
        gap_span[T_RAS] = cfg.ras;
        gap_span[T_RRD] = cfg.rrd;
        gap_span[T_RP] = cfg.rp;
        gap_span[T_RC] = cfg.rc;
        gap_span[T_WR] = cfg.wr;
        gap_span[T_RW] = cfg.rd_wr;
    end

    // timers are cleared by either reset so a restart never inherits stale spacing
    gsm_gap_timer #(
        .CH(T_NUM),
        .W(4)
    ) u_gap (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr(soft_rst),
        .start(gap_start),
        .span(gap_span),
        .done(gap_done)
    );

    // refresh runs only once the mode word is in place
    gsm_refresh_tick #(
        .W(11)
    ) u_ref (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .run(cfg_valid && !soft_rst), // RQ18
        .interval(cfg.ref_interval), // RQ7
        .tick(ref_tick)
    );

    // next-state: mode word, phase, pending refresh and read answer
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = host_read;
        st_nxt.rdata = '0;
        if (host_read && mode_hit) begin
            st_nxt.rdata = (st_r.mode & MODE_STORE_MASK) | MODE_READ_ONE; // RQ15
        end
        // a tick in the same cycle as the refresh issue keeps the request up
        if (issue && cmd_code == CMD_REF) begin
            st_nxt.ref_pending = 1'b0;
        end
        if (ref_tick) begin
            st_nxt.ref_pending = 1'b1;
        end
        if (soft_rst) begin
            st_nxt.phase = PH_WAIT_CFG; // RQ2
            st_nxt.ref_pending = 1'b0;
        end else if (host_write) begin
            // later writes are taken too; changing timing mid-traffic is the host's hazard
            st_nxt.mode = host_wdata & MODE_STORE_MASK; // RQ1
            st_nxt.phase = PH_RUN; // RQ18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '{PH_WAIT_CFG, MODE_RESET, 1'b0, 32'h0000_0000, 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign host_rdata = st_r.rdata;
    assign host_rvalid = st_r.rvalid;
    assign refresh_req = st_r.ref_pending;

    // helper counters: clocks since each command kind, saturating
    logic [7:0] since_act;
    logic [7:0] since_pre;
    logic [7:0] since_ref;
    logic [7:0] since_wr;
    logic [7:0] since_rd;

    function automatic logic [7:0] since_step(input logic [7:0] v, input logic hit);
        return hit ? 8'h01 : ((v == 8'hff) ? v : 8'(v + 1'b1));
    endfunction : since_step

    function automatic logic [7:0] floor1(input logic [3:0] s);
        return (s == 4'h0) ? 8'h01 : {4'h0, s};
    endfunction : floor1

    always_ff @(posedge ref_clk) begin
        if (!rstn || soft_rst) begin
            since_act <= 8'hff;
            since_pre <= 8'hff;
            since_ref <= 8'hff;
            since_wr <= 8'hff;
            since_rd <= 8'hff;
        end else begin
            since_act <= since_step(since_act, issue && cmd_code == CMD_ACT);
            since_pre <= since_step(since_pre, issue && cmd_code == CMD_PRE);
            since_ref <= since_step(since_ref, issue && cmd_code == CMD_REF);
            since_wr <= since_step(since_wr, issue && cmd_code == CMD_WR);
            since_rd <= since_step(since_rd, issue && cmd_code == CMD_RD);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_tick_seen;
        ref_tick && !soft_rst;
    endsequence

    sequence s_req_up;
        refresh_req;
    endsequence

    chk_col_after_act: assert property ( // RQ10
        issue && (cmd_code == CMD_RD || cmd_code == CMD_WR) |-> since_act >= floor1(cfg.rcd))
        else $error("column command too soon after activate");
    chk_pre_after_act: assert property ( // RQ11
        issue && cmd_code == CMD_PRE |-> since_act >= floor1(cfg.ras))
        else $error("precharge before row active minimum");
    chk_act_after_pre: assert property ( // RQ12
        issue && cmd_code == CMD_ACT |-> since_pre >= floor1(cfg.rp))
        else $error("activate too soon after precharge");
    chk_act_after_ref: assert property ( // RQ13
        issue && cmd_code == CMD_ACT |-> since_ref >= floor1(cfg.rc))
        else $error("activate too soon after refresh");
    chk_act_to_act: assert property ( // RQ14
        issue && cmd_code == CMD_ACT |-> since_act >= floor1(cfg.rrd))
        else $error("activates spaced too closely");
    chk_write_recovery: assert property ( // RQ16
        issue && (cmd_code == CMD_RD || cmd_code == CMD_PRE) |-> since_wr >= floor1(cfg.wr))
        else $error("write recovery violated");
    chk_read_write_gap: assert property ( // RQ9
        issue && cmd_code == CMD_WR |-> since_rd >= floor1(cfg.rd_wr))
        else $error("write too soon after read data");
    chk_hold_no_cfg: assert property ( // RQ18
        !cfg_valid |-> !issue && !ref_tick)
        else $error("traffic before mode word written");
    chk_soft_keeps_mode: assert property ( // RQ2
        soft_rst |=> st_r.mode == $past(st_r.mode) && !cfg_valid)
        else $error("soft reset changed mode word");
    chk_rsv_reads_one: assert property ( // RQ15
        host_sel && !host_wr && mode_hit |=> host_rvalid && host_rdata[RSV_ONE_BIT]
            && host_rdata[29:27] == 3'h0)
        else $error("reserved bits read wrong");
    chk_refresh_raise: assert property ( // RQ7
        s_tick_seen |=> s_req_up)
        else $error("refresh tick lost");

endmodule : gsm_mode_timing

// ### gsm_pkg.sv
// Purpose: shared constants and types for the graphics memory mode and timing block
// Assumes: one 32-bit mode word at a fixed host offset, timings counted in ref_clk cycles
// Notes: field positions and codes are named once here and used by the mode block, the sequencer model and the bench
package gsm_pkg;

    // host offset of the memory interface mode word (byte address)
    localparam logic [11:0] MODE_OFFSET = 12'h0ffc;

    // field positions inside the mode word
    localparam int CL_LSB = 0;
    localparam int BW_BIT = 3;
    localparam int GEO_LSB = 4;
    localparam int RTS_LSB = 7;
    localparam int GAP_LSB = 10;
    localparam int RCD_LSB = 12;
    localparam int RAS_LSB = 14;
    localparam int RP_LSB = 17;
    localparam int RC_LSB = 19;
    localparam int RRD_LSB = 23;
    localparam int RSV_ONE_BIT = 26;
    localparam int WR_BIT = 30;

    // reset value of stored bits, the bits that store, and the bit that always reads one
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] MODE_STORE_MASK = 32'h41ff_ffff;
    localparam logic [31:0] MODE_READ_ONE = 32'h0400_0000;

    // cas latency codes
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [2:0] CL_CODE_2 = 3'h2;

    // address geometry codes
    localparam logic [2:0] GEO_15_9 = 3'h1;
    localparam logic [2:0] GEO_14_9 = 3'h7;
    localparam logic [2:0] GEO_14_8A = 3'h6;
    localparam logic [2:0] GEO_14_8B = 3'h0;
    localparam logic [2:0] GEO_13_8 = 3'h5;
    localparam logic [2:0] GEO_FAST = 3'h4;

    // read-to-write gap codes and the clocks they give after the last read data
    localparam logic [1:0] GAP_CODE_A = 2'h2;
    localparam logic [1:0] GAP_CODE_B = 2'h0;
    localparam logic [3:0] RD_WR_GAP = 4'h2;

    // legal code ranges of the timing fields and the write recovery spans
    localparam logic [2:0] RAS_MIN_CODE = 3'h2;
    localparam logic [1:0] RP_MIN_CODE = 2'h1;
    localparam logic [3:0] RC_MIN_CODE = 4'h3;
    localparam logic [3:0] RC_MAX_CODE = 4'ha;
    localparam logic [1:0] RRD_MIN_CODE = 2'h2;
    localparam logic [3:0] WR_SPAN_SET = 4'h2;
    localparam logic [3:0] WR_SPAN_CLR = 4'h1;

    // refresh interval figures in internal clocks
    localparam logic [10:0] REF_CODE0_CLK = 11'h180;
    localparam logic [10:0] REF_CODE7_CLK = 11'h610;
    localparam logic [2:0] REF_CODE_MAX = 3'h7;

    // spacing timer channels
    localparam int T_RCD = 0;
    localparam int T_RAS = 1;
    localparam int T_RP = 2;
    localparam int T_RC = 3;
    localparam int T_RRD = 4;
    localparam int T_WR = 5;
    localparam int T_RW = 6;
    localparam int T_NUM = 7;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF} gsm_cmd_t;
    typedef enum logic {PH_WAIT_CFG, PH_RUN} gsm_phase_t;

    typedef struct packed {
        logic fast_cycle;
        logic [3:0] addr_bits;
        logic [1:0] bank_bits;
        logic [3:0] row_bits;
        logic [3:0] col_bits;
    } gsm_geom_t;

    typedef struct packed {
        logic [3:0] cas;
        logic wide_bus;
        gsm_geom_t geom;
        logic [10:0] ref_interval;
        logic [3:0] rcd;
        logic [3:0] ras;
        logic [3:0] rp;
        logic [3:0] rc;
        logic [3:0] rrd;
        logic [3:0] wr;
        logic [3:0] rd_wr;
    } gsm_cfg_t;

endpackage : gsm_pkg

// ### gsm_gap_timer.sv
// Purpose: bank of minimum-spacing timers, one per timing parameter, each shared by every command it holds back
// Assumes: span is the least number of clocks from a start to the next allowed command
// Notes: a span of 0 behaves as 1, since two commands never share a cycle
`timescale 1ns/100ps
module gsm_gap_timer #(
    parameter int CH = 7,
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic [CH-1:0] start,
    input wire logic [CH-1:0][W-1:0] span,
    output logic [CH-1:0] done
);
    typedef struct packed {
        logic [CH-1:0][W-1:0] cnt;
    } gsm_gap_state_t;

    gsm_gap_state_t st_r;
    gsm_gap_state_t st_nxt;

    // load span minus one so the next command lands exactly span clocks later
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < CH; i++) begin
            if (clr) begin
                st_nxt.cnt[i] = '0;
            end else if (start[i]) begin
                st_nxt.cnt[i] = (span[i] == '0) ? '0 : W'(span[i] - 1'b1);
            end else if (st_r.cnt[i] != '0) begin
                st_nxt.cnt[i] = W'(st_r.cnt[i] - 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a channel is clear once its count has run out
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            done[i] = (st_r.cnt[i] == '0);
        end
    end

endmodule : gsm_gap_timer

// ### gsm_refresh_tick.sv
// Purpose: refresh interval generator giving one pulse per programmed interval
// Assumes: interval is at least two clocks and stays fixed while run is high
// Notes: the count restarts from zero whenever run drops
`timescale 1ns/100ps
module gsm_refresh_tick #(
    parameter int W = 11
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [W-1:0] interval,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } gsm_ref_state_t;

    gsm_ref_state_t st_r;
    gsm_ref_state_t st_nxt;

    // count 0 .. interval-1 and pulse on the wrap, so pulses are interval clocks apart
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= W'(interval - 1'b1)) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = W'(st_r.cnt + 1'b1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule : gsm_refresh_tick

// ### gsm_seq_model.sv
// Purpose: command source standing where the memory sequencer sits
// Assumes: drives on the falling edge, samples ready late in the low phase
// Notes: an idle port shows NOP so no stale command lingers
`timescale 1ns/100ps
module gsm_seq_model (
    input wire logic ref_clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output gsm_pkg::gsm_cmd_t cmd_code
);
    import gsm_pkg::*;

    // idle until the bench asks for a command
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
    end

    // hold one command until ready is seen or the lim refusals run out; a refusal keeps it offered
    task automatic issue(input gsm_cmd_t c, input int lim, output int waits);
        waits = 0;
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        forever begin
            #9;
            if (cmd_ready === 1'b1 || waits == lim) break;
            @(negedge ref_clk);
            waits++;
        end
        // never pushes a command through without ready; a last refusal is counted too,
        // so a command taken at the limit edge is not mistaken for a refused one
        if (cmd_ready === 1'b1) begin
            @(posedge ref_clk);
        end else begin
            waits++;
        end
    endtask : issue

    // release the port
    task automatic idle();
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
    endtask : idle
endmodule : gsm_seq_model

// ### gsm_mode_timing_tb.sv
// Purpose: self-checking bench for the memory mode word and spacing guard
// Assumes: one clock, host strobes and commands driven on the falling edge
// Notes: spacing is measured as refused cycles before a command is taken
`timescale 1ns/100ps
module gsm_mode_timing_tb;
    import gsm_pkg::*;
    logic ref_clk, rstn, soft_rst, host_sel, host_wr;
    logic [11:0] host_addr;
    logic [31:0] host_wdata, host_rdata, d, wa, wb;
    logic host_rvalid, cmd_valid, cmd_ready, refresh_req, cfg_valid, cfg_illegal;
    gsm_cmd_t cmd_code;
    gsm_cfg_t cfg;
    int err_count = 0;
    int num_checks = 0;
    int w;

    gsm_mode_timing dut (.ref_clk(ref_clk), .rstn(rstn), .soft_rst(soft_rst),
        .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
        .refresh_req(refresh_req), .cfg(cfg), .cfg_valid(cfg_valid),
        .cfg_illegal(cfg_illegal));
    gsm_seq_model seq (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // hang guard, well beyond the few thousand cycles the tests need
    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // builds a mode word; bit 26 is always written as zero
    function automatic logic [31:0] mw(logic [2:0] cl, logic bw, logic [2:0] geo,
        logic [2:0] rts, logic [1:0] rcd, logic [2:0] ras, logic [1:0] rp,
        logic [3:0] rc, logic [1:0] rrd, logic write_recovery, logic [1:0] gap);
        return {1'b0, write_recovery, 5'h00, rrd, rc, rp, ras, rcd, gap, rts, geo, bw, cl};
    endfunction : mw

    task automatic host_write(input logic [11:0] a, input logic [31:0] v);
        @(negedge ref_clk);
        host_sel = 1'b1;
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = v;
        @(negedge ref_clk);
        host_sel = 1'b0;
    endtask : host_write

    task automatic host_read(input logic [11:0] a, output logic [31:0] v);
        @(negedge ref_clk);
        host_sel = 1'b1;
        host_wr = 1'b0;
        host_addr = a;
        @(negedge ref_clk);
        host_sel = 1'b0;
        chk(host_rvalid, 1);
        v = host_rdata;
    endtask : host_read

    task automatic soft_pulse();
        @(negedge ref_clk);
        soft_rst = 1'b1;
        @(negedge ref_clk);
        soft_rst = 1'b0;
    endtask : soft_pulse

    task automatic t_reset();
        chk(cfg_valid, 0);
        seq.issue(CMD_REF, 3, w);
        chk(w, 4);
        seq.idle();
        host_read(MODE_OFFSET, d);
        chk(d, MODE_RESET | MODE_READ_ONE);
        repeat (400) @(negedge ref_clk);
        chk(refresh_req, 0);
        $display("done: reset");
    endtask : t_reset

    task automatic t_regs();
        host_write(MODE_OFFSET, 32'hfbff_ffff);
        chk(cfg_valid, 1);
        host_write(12'hff8, 32'h0000_0000);
        host_read(MODE_OFFSET, d);
        chk(d, (32'hfbff_ffff & MODE_STORE_MASK) | MODE_READ_ONE);
        host_read(12'hff8, d);
        chk(d, 0);
        $display("done: registers");
    endtask : t_regs

    task automatic t_fields();
        logic [2:0] geo [6] = '{3'h1, 3'h7, 3'h6, 3'h0, 3'h5, 3'h4};
        logic [14:0] gx [6] = '{{1'b0, 4'hf, 2'h2, 4'hd, 4'h9}, {1'b0, 4'he, 2'h2, 4'hc, 4'h9},
            {1'b0, 4'he, 2'h2, 4'hc, 4'h8}, {1'b0, 4'he, 2'h2, 4'hc, 4'h8},
            {1'b0, 4'hd, 2'h2, 4'hb, 4'h8}, {1'b1, 4'hc, 2'h1, 4'hb, 4'h8}};
        int ri;
        for (int i = 0; i < 8; i++) begin
            ri = (i == 0) ? 384 : (i == 7) ? 1552 : 64 * i;
            host_write(MODE_OFFSET, mw(i[0] ? 3'h3 : 3'h2, i[0], geo[i % 6], i[2:0],
                i[1:0], 3'(2 + i % 6), 2'(1 + i % 3), 4'(3 + i), 2'(2 + i % 2), i[0],
                {i[0], 1'b0}));
            chk(cfg.cas, i[0] ? 3 : 2);
            chk(cfg.wide_bus, i[0]);
            chk(cfg.geom, gx[i % 6]);
            chk(cfg.ref_interval, ri);
            chk(cfg.rcd, i[1:0]);
            chk(cfg.ras, 2 + i % 6);
            chk(cfg.rp, 1 + i % 3);
            chk(cfg.rc, 3 + i);
            chk(cfg.rrd, 2 + i % 2);
            chk(cfg.wr, i[0] ? 2 : 1);
            chk(cfg.rd_wr, i[0] ? 5 : 4);
            chk(cfg_illegal, 0);
        end
        $display("done: fields");
    endtask : t_fields

    task automatic t_illegal();
        logic [31:0] clr [5] = '{32'h0000_0007, 32'h0000_0070, 32'h0001_c000,
            32'h0078_0000, 32'h0000_0c00};
        logic [31:0] setv [5] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_4000,
            32'h0010_0000, 32'h0000_0400};
        for (int i = 0; i < 5; i++) begin
            host_write(MODE_OFFSET, (wa & ~clr[i]) | setv[i]);
            chk(cfg_illegal, 1);
        end
        $display("done: forbidden codes");
    endtask : t_illegal

    task automatic t_soft();
        host_write(MODE_OFFSET, wb);
        soft_pulse();
        host_read(MODE_OFFSET, d);
        chk(d, (wb & MODE_STORE_MASK) | MODE_READ_ONE);
        chk(cfg_valid, 0);
        seq.issue(CMD_ACT, 3, w);
        chk(w, 4);
        seq.idle();
        $display("done: soft reset");
    endtask : t_soft

    task automatic t_refresh();
        int codes [3] = '{1, 0, 7};
        int k;
        int n;
        for (int j = 0; j < 3; j++) begin
            n = codes[j];
            soft_pulse();
            host_write(MODE_OFFSET, mw(3'h3, 1'b0, 3'h1, n[2:0], 2'h1, 3'h2, 2'h1, 4'h3,
                2'h2, 1'b0, 2'h0));
            k = 0;
            while (refresh_req !== 1'b1 && k < 2000) begin
                @(negedge ref_clk);
                k++;
            end
            chk(k, (n == 0 ? 384 : n == 7 ? 1552 : 64 * n) + 1);
            seq.issue(CMD_ACT, 2, w);
            chk(w, 3);
            seq.issue(CMD_REF, 4, w);
            chk(w, 0);
            seq.idle();
            chk(refresh_req, 0);
        end
        $display("done: refresh");
    endtask : t_refresh

    // each step byte holds a command code and the refused cycles expected
    task automatic run_seq(input logic [31:0] word, input int n, input logic [71:0] s);
        logic [7:0] b;
        soft_pulse();
        host_write(MODE_OFFSET, word);
        for (int i = 0; i < n; i++) begin
            b = s[8*(n-1-i)+:8];
            seq.issue(gsm_cmd_t'(b[6:4]), 20, w);
            chk(w, b[3:0]);
        end
        seq.idle();
        $display("done: spacing run");
    endtask : run_seq

    // reset for five cycles, then the scenarios in turn
    initial begin
        rstn = 1'b0;
        soft_rst = 1'b0;
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_addr = 12'h000;
        host_wdata = 32'h0000_0000;
        wa = mw(3'h3, 1'b0, 3'h1, 3'h7, 2'h2, 3'h3, 2'h2, 4'h4, 2'h3, 1'b1, 2'h2);
        wb = mw(3'h2, 1'b1, 3'h5, 3'h7, 2'h0, 3'h2, 2'h1, 4'h3, 2'h2, 1'b0, 2'h0);
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_fields();
        t_illegal();
        t_soft();
        t_refresh();
        run_seq(wa, 9, 72'h10_2134_4111_1242_5113);
        run_seq(wb, 5, 72'h00_0000_0010_2033_2040);
        finish_test();
    end
endmodule : gsm_mode_timing_tb
